// >>> logic/lnb_dev.sv
// serial port end: break send, sync pass-through, break receive and auto-baud
`timescale 1ns/100ps
`default_nettype none
module lnb_dev (
   input  wire logic       clk_i,
   input  wire logic       rstn_i,
   input  wire logic       ce_i,
   lnb_link_if.dev         link,
   input  wire logic       tx_enable_i,
   input  wire logic       break_request_set_i,
   input  wire logic       tx_write_i,
   input  wire logic [7:0] tx_data_i,
   input  wire logic       rx_read_i,
   input  wire logic       wake_on_break_set_i,
   input  wire logic       autobaud_set_i,
   output logic            break_request_o,
   output logic            tx_shift_empty_o,
   output logic            tx_buffer_empty_flag_o,
   output logic            rx_flag_o,
   output logic            framing_error_flag_o,
   output logic [7:0]      rx_data_o,
   output logic            wake_on_break_enable_o,
   output logic            autobaud_enable_o,
   output logic [15:0]     baud_div_o
);
   // transmit buffer, two entries
   logic [7:0]  mem_r [2];
   logic [7:0]  mem_nxt [2];
   logic        wp_r, wp_nxt, rp_r, rp_nxt;
   logic [1:0]  cnt_r, cnt_nxt;
   logic        push, pop;
   // transmitter
   lnb_pkg::lnb_tx_st_t tx_st_r, tx_st_nxt;
   logic [15:0] tx_cnt_r, tx_cnt_nxt;
   logic [3:0]  tx_bit_r, tx_bit_nxt, tx_last;
   logic [7:0]  tx_sh_r, tx_sh_nxt;
   logic        tx_brk_r, tx_brk_nxt, tx_drv_r, tx_drv_nxt;
   logic        brk_req_r, brk_req_nxt, brk_clr;
   logic        empty_r, empty_nxt, space_r, space_nxt;
   logic [15:0] div_m1;
   // receiver
   logic        s1_r, s2_r, prev_r;
   logic        rise, fall;
   lnb_pkg::lnb_rx_st_t rx_st_r, rx_st_nxt;
   logic [15:0] rx_cnt_r, rx_cnt_nxt;
   logic [3:0]  rx_bit_r, rx_bit_nxt;
   logic [7:0]  rx_sh_r, rx_sh_nxt, rx_data_r, rx_data_nxt;
   logic        rx_flag_r, rx_flag_nxt, framing_error_flag_r, framing_error_flag_nxt, rx_set;
   logic        wue_r, wue_nxt, abd_r, abd_nxt;
   logic [2:0]  edge_r, edge_nxt;
   logic [18:0] abd_cnt_r, abd_cnt_nxt;
   logic [15:0] div_r, div_nxt;

   assign div_m1 = 16'(div_r - 16'h0001);
   assign tx_last = 4'((tx_brk_r ? lnb_pkg::BREAK_BITS : lnb_pkg::DATA_BITS) - 4'h1);
   assign rise = ~prev_r & s2_r;
   assign fall = prev_r & ~s2_r;

   always_comb
   begin
      tx_st_nxt  = tx_st_r;
      tx_cnt_nxt = tx_cnt_r;
      tx_bit_nxt = tx_bit_r;
      tx_sh_nxt  = tx_sh_r;
      tx_brk_nxt = tx_brk_r;
      tx_drv_nxt = tx_drv_r;
      brk_clr    = 1'b0;
      pop        = 1'b0;
      case (tx_st_r)
         lnb_pkg::TX_IDLE:
         begin
            tx_drv_nxt = 1'b1;
            // frame only starts once a byte sits in the buffer
            if (tx_enable_i && cnt_r != 2'h0)
            begin
               pop        = 1'b1;
               tx_st_nxt  = lnb_pkg::TX_START;
               tx_cnt_nxt = div_m1;
               tx_drv_nxt = 1'b0;
               tx_brk_nxt = brk_req_r;
               tx_sh_nxt  = brk_req_r ? 8'h00 : mem_r[rp_r];
            end
         end
         lnb_pkg::TX_START:
            if (tx_cnt_r == 16'h0000)
            begin
               tx_st_nxt  = lnb_pkg::TX_BITS;
               tx_cnt_nxt = div_m1;
               tx_bit_nxt = 4'h0;
               tx_drv_nxt = tx_sh_r[0];
            end
            else
               tx_cnt_nxt = 16'(tx_cnt_r - 16'h0001);
         lnb_pkg::TX_BITS:
            if (tx_cnt_r == 16'h0000)
            begin
               tx_cnt_nxt = div_m1;
               // break runs twelve zero bits after the start bit, zeros refill the shifter
               if (tx_bit_r == tx_last)
               begin
                  tx_st_nxt  = lnb_pkg::TX_STOP;
                  tx_drv_nxt = 1'b1;
               end
               else
               begin
                  tx_bit_nxt = 4'(tx_bit_r + 4'h1);
                  tx_sh_nxt  = {1'b0, tx_sh_r[7:1]};
                  tx_drv_nxt = tx_sh_r[1];
               end
            end
            else
               tx_cnt_nxt = 16'(tx_cnt_r - 16'h0001);
         lnb_pkg::TX_STOP:
            if (tx_cnt_r == 16'h0000)
            begin
               tx_st_nxt  = lnb_pkg::TX_IDLE;
               brk_clr    = tx_brk_r;
               tx_brk_nxt = 1'b0;
            end
            else
               tx_cnt_nxt = 16'(tx_cnt_r - 16'h0001);
         default:
            tx_st_nxt = lnb_pkg::TX_IDLE;
      endcase
      // a new request in the clearing cycle survives
      brk_req_nxt = break_request_set_i | (brk_req_r & ~brk_clr);
      empty_nxt   = (tx_st_nxt == lnb_pkg::TX_IDLE);
   end

   always_comb
   begin
      mem_nxt = mem_r;
      // writes into a full buffer are dropped
      push    = tx_write_i && cnt_r != lnb_pkg::TX_BUF_DEPTH;
      wp_nxt  = wp_r;
      rp_nxt  = rp_r;
      if (push)
      begin
         mem_nxt[wp_r] = tx_data_i;
         wp_nxt        = ~wp_r;
      end
      if (pop)
         rp_nxt = ~rp_r;
      cnt_nxt   = 2'(cnt_r + {1'b0, push} - {1'b0, pop});
      space_nxt = (cnt_nxt != lnb_pkg::TX_BUF_DEPTH);
   end

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         tx_st_r   <= lnb_pkg::TX_IDLE;
         tx_cnt_r  <= 16'h0000;
         tx_bit_r  <= 4'h0;
         tx_sh_r   <= 8'h00;
         tx_brk_r  <= 1'b0;
         tx_drv_r  <= 1'b1;
         brk_req_r <= 1'b0;
         empty_r   <= 1'b1;
         mem_r     <= '{8'h00, 8'h00};
         wp_r      <= 1'b0;
         rp_r      <= 1'b0;
         cnt_r     <= 2'h0;
         space_r   <= 1'b1;
      end
      else if (ce_i)
      begin
         tx_st_r   <= tx_st_nxt;
         tx_cnt_r  <= tx_cnt_nxt;
         tx_bit_r  <= tx_bit_nxt;
         tx_sh_r   <= tx_sh_nxt;
         tx_brk_r  <= tx_brk_nxt;
         tx_drv_r  <= tx_drv_nxt;
         brk_req_r <= brk_req_nxt;
         empty_r   <= empty_nxt;
         mem_r     <= mem_nxt;
         wp_r      <= wp_nxt;
         rp_r      <= rp_nxt;
         cnt_r     <= cnt_nxt;
         space_r   <= space_nxt;
      end
   end

   always_comb
   begin
      rx_st_nxt   = rx_st_r;
      rx_cnt_nxt  = rx_cnt_r;
      rx_bit_nxt  = rx_bit_r;
      rx_sh_nxt   = rx_sh_r;
      rx_data_nxt = rx_data_r;
      framing_error_flag_nxt    = framing_error_flag_r;
      edge_nxt    = edge_r;
      abd_cnt_nxt = abd_cnt_r;
      div_nxt     = div_r;
      rx_set      = 1'b0;
      wue_nxt     = wue_r | wake_on_break_set_i;
      abd_nxt     = abd_r | autobaud_set_i;
      case (rx_st_r)
         lnb_pkg::RX_IDLE:
            // wake sampling has priority so auto-baud sees the next byte
            if (wue_r)
            begin
               if (fall)
                  rx_st_nxt = lnb_pkg::RX_WAKE;
            end
            else if (abd_r)
            begin
               if (fall)
                  rx_st_nxt = lnb_pkg::RX_ABD_START;
            end
            else if (fall)
            begin
               rx_st_nxt  = lnb_pkg::RX_START;
               rx_cnt_nxt = {1'b0, div_r[15:1]};
            end
         lnb_pkg::RX_WAKE:
            if (rise)
            begin
               rx_set    = 1'b1;
               wue_nxt   = wake_on_break_set_i;
               rx_st_nxt = lnb_pkg::RX_IDLE;
            end
         lnb_pkg::RX_ABD_START:
            if (rise)
            begin
               rx_st_nxt   = lnb_pkg::RX_ABD_COUNT;
               abd_cnt_nxt = 19'h00001;
               edge_nxt    = 3'h1;
            end
         lnb_pkg::RX_ABD_COUNT:
         begin
            abd_cnt_nxt = 19'(abd_cnt_r + 19'h00001);
            if (rise)
            begin
               edge_nxt = 3'(edge_r + 3'h1);
               // edges one to five span eight bit periods
               if (3'(edge_r + 3'h1) == lnb_pkg::ABD_EDGES)
               begin
                  div_nxt   = abd_cnt_r[18:lnb_pkg::ABD_SHIFT];
                  abd_nxt   = autobaud_set_i;
                  rx_set    = 1'b1;
                  rx_st_nxt = lnb_pkg::RX_IDLE;
               end
            end
         end
         lnb_pkg::RX_START:
            if (rx_cnt_r == 16'h0000)
            begin
               rx_st_nxt  = s2_r ? lnb_pkg::RX_IDLE : lnb_pkg::RX_BITS;
               rx_cnt_nxt = div_m1;
               rx_bit_nxt = 4'h0;
            end
            else
               rx_cnt_nxt = 16'(rx_cnt_r - 16'h0001);
         lnb_pkg::RX_BITS:
            if (rx_cnt_r == 16'h0000)
            begin
               rx_cnt_nxt = div_m1;
               rx_sh_nxt  = {s2_r, rx_sh_r[7:1]};
               rx_bit_nxt = 4'(rx_bit_r + 4'h1);
               if (rx_bit_r == 4'(lnb_pkg::DATA_BITS - 4'h1))
                  rx_st_nxt = lnb_pkg::RX_STOP;
            end
            else
               rx_cnt_nxt = 16'(rx_cnt_r - 16'h0001);
         lnb_pkg::RX_STOP:
            if (rx_cnt_r == 16'h0000)
            begin
               // a break lands here with zero data and a low stop
               rx_set      = 1'b1;
               rx_data_nxt = rx_sh_r;
               framing_error_flag_nxt    = ~s2_r;
               rx_st_nxt   = s2_r ? lnb_pkg::RX_IDLE : lnb_pkg::RX_BRKWAIT;
            end
            else
               rx_cnt_nxt = 16'(rx_cnt_r - 16'h0001);
         lnb_pkg::RX_BRKWAIT:
            // hold off until the line recovers, else the break refires
            if (s2_r)
               rx_st_nxt = lnb_pkg::RX_IDLE;
         default:
            rx_st_nxt = lnb_pkg::RX_IDLE;
      endcase
      rx_flag_nxt = rx_set | (rx_flag_r & ~rx_read_i);
   end

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         s1_r      <= 1'b1;
         s2_r      <= 1'b1;
         prev_r    <= 1'b1;
         rx_st_r   <= lnb_pkg::RX_IDLE;
         rx_cnt_r  <= 16'h0000;
         rx_bit_r  <= 4'h0;
         rx_sh_r   <= 8'h00;
         rx_data_r <= 8'h00;
         rx_flag_r <= 1'b0;
         framing_error_flag_r    <= 1'b0;
         wue_r     <= 1'b0;
         abd_r     <= 1'b0;
         edge_r    <= 3'h0;
         abd_cnt_r <= 19'h00000;
         div_r     <= lnb_pkg::DIV_RST;
      end
      else if (ce_i)
      begin
         s1_r      <= link.line;
         s2_r      <= s1_r;
         prev_r    <= s2_r;
         rx_st_r   <= rx_st_nxt;
         rx_cnt_r  <= rx_cnt_nxt;
         rx_bit_r  <= rx_bit_nxt;
         rx_sh_r   <= rx_sh_nxt;
         rx_data_r <= rx_data_nxt;
         rx_flag_r <= rx_flag_nxt;
         framing_error_flag_r    <= framing_error_flag_nxt;
         wue_r     <= wue_nxt;
         abd_r     <= abd_nxt;
         edge_r    <= edge_nxt;
         abd_cnt_r <= abd_cnt_nxt;
         div_r     <= div_nxt;
      end
   end

   assign link.dev_drv           = tx_drv_r;
   assign break_request_o        = brk_req_r;
   assign tx_shift_empty_o       = empty_r;
   assign tx_buffer_empty_flag_o = space_r;
   assign rx_flag_o              = rx_flag_r;
   assign framing_error_flag_o   = framing_error_flag_r;
   assign rx_data_o              = rx_data_r;
   assign wake_on_break_enable_o = wue_r;
   assign autobaud_enable_o      = abd_r;
   assign baud_div_o             = div_r;
endmodule : lnb_dev
`default_nettype wire

// >>> common/lnb_pkg.sv
// shared constants and state types for the lin break serial ends
package lnb_pkg;
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned BIT_NS        = 1000;
   localparam int unsigned BIT_CYC       = BIT_NS / CLK_PERIOD_NS;
   localparam int unsigned DIV_W         = 16;
   localparam int unsigned ABD_W         = 19;
   localparam int unsigned ABD_SHIFT     = 3;
   localparam logic [15:0] DIV_RST         = 16'(BIT_CYC);
   localparam logic [3:0]  DATA_BITS       = 4'h8;
   localparam logic [3:0]  BREAK_BITS      = 4'hc;
   localparam logic [3:0]  NODE_BREAK_BITS = 4'hd;
   localparam logic [7:0]  SYNC_BYTE       = 8'h55;
   localparam logic [2:0]  ABD_EDGES       = 3'h5;
   localparam logic [1:0]  TX_BUF_DEPTH    = 2'h2;

   typedef enum {TX_IDLE, TX_START, TX_BITS, TX_STOP, TX_BRK, TX_DELIM} lnb_tx_st_t;
   typedef enum {RX_IDLE, RX_START, RX_BITS, RX_STOP, RX_BRKWAIT, RX_WAKE,
                 RX_ABD_START, RX_ABD_COUNT} lnb_rx_st_t;
endpackage : lnb_pkg

// >>> common/lnb_link_if.sv
// single-wire serial line joining the port and the far lin node
`timescale 1ns/100ps
`default_nettype none
interface lnb_link_if;
   logic dev_drv;
   logic node_drv;
   logic line;
   // recessive high, either end pulls it low
   assign line = dev_drv & node_drv;
   modport dev  (output dev_drv, input line);
   modport node (output node_drv, input line);
endinterface : lnb_link_if
`default_nettype wire

// >>> logic/lnb_node.sv
// far lin node: sends header or bytes, receives bytes at the nominal rate
`timescale 1ns/100ps
`default_nettype none
module lnb_node (
   input  wire logic       clk_i,
   input  wire logic       rstn_i,
   input  wire logic       ce_i,
   lnb_link_if.node        link,
   input  wire logic       header_i,
   input  wire logic       byte_valid_i,
   input  wire logic [7:0] byte_i,
   output logic            busy_o,
   output logic            rx_valid_o,
   output logic [7:0]      rx_byte_o,
   output logic            rx_framing_error_flag_o
);
   localparam logic [15:0] DM1 = 16'(lnb_pkg::DIV_RST - 16'h0001);
   lnb_pkg::lnb_tx_st_t st_r, st_nxt;
   lnb_pkg::lnb_rx_st_t rs_r, rs_nxt;
   logic [15:0] cnt_r, cnt_nxt, rc_r, rc_nxt;
   logic [3:0]  bit_r, bit_nxt, rb_r, rb_nxt;
   logic [7:0]  sh_r, sh_nxt, rsh_r, rsh_nxt, rbyte_r, rbyte_nxt;
   logic        drv_r, drv_nxt, busy_r, busy_nxt;
   logic        s1_r, s2_r, prev_r, rv_r, rv_nxt, fe_r, fe_nxt;

   always_comb
   begin
      st_nxt   = st_r;
      cnt_nxt  = (cnt_r == 16'h0000) ? DM1 : 16'(cnt_r - 16'h0001);
      bit_nxt  = bit_r;
      sh_nxt   = sh_r;
      drv_nxt  = drv_r;
      case (st_r)
         lnb_pkg::TX_IDLE:
         begin
            cnt_nxt = DM1;
            drv_nxt = 1'b1;
            // header: break, delimiter, then the sync byte
            if (header_i)
            begin
               st_nxt   = lnb_pkg::TX_BRK;
               drv_nxt  = 1'b0;
               bit_nxt  = 4'h0;
            end
            else if (byte_valid_i)
            begin
               st_nxt  = lnb_pkg::TX_START;
               drv_nxt = 1'b0;
               sh_nxt  = byte_i;
            end
         end
         lnb_pkg::TX_BRK:
            if (cnt_r == 16'h0000)
            begin
               bit_nxt = 4'(bit_r + 4'h1);
               if (bit_r == 4'(lnb_pkg::NODE_BREAK_BITS - 4'h1))
               begin
                  st_nxt  = lnb_pkg::TX_DELIM;
                  drv_nxt = 1'b1;
               end
            end
         lnb_pkg::TX_DELIM:
            if (cnt_r == 16'h0000)
            begin
               st_nxt   = lnb_pkg::TX_START;
               drv_nxt  = 1'b0;
               sh_nxt   = lnb_pkg::SYNC_BYTE;
            end
         lnb_pkg::TX_START:
            if (cnt_r == 16'h0000)
            begin
               st_nxt  = lnb_pkg::TX_BITS;
               bit_nxt = 4'h0;
               drv_nxt = sh_r[0];
            end
         lnb_pkg::TX_BITS:
            if (cnt_r == 16'h0000)
            begin
               bit_nxt = 4'(bit_r + 4'h1);
               sh_nxt  = {1'b0, sh_r[7:1]};
               drv_nxt = sh_r[1];
               if (bit_r == 4'(lnb_pkg::DATA_BITS - 4'h1))
               begin
                  st_nxt  = lnb_pkg::TX_STOP;
                  drv_nxt = 1'b1;
               end
            end
         lnb_pkg::TX_STOP:
            if (cnt_r == 16'h0000)
               st_nxt = lnb_pkg::TX_IDLE;
         default:
            st_nxt = lnb_pkg::TX_IDLE;
      endcase
      busy_nxt = (st_nxt != lnb_pkg::TX_IDLE);
   end

   always_comb
   begin
      rs_nxt    = rs_r;
      rc_nxt    = (rc_r == 16'h0000) ? DM1 : 16'(rc_r - 16'h0001);
      rb_nxt    = rb_r;
      rsh_nxt   = rsh_r;
      rbyte_nxt = rbyte_r;
      fe_nxt    = fe_r;
      rv_nxt    = 1'b0;
      case (rs_r)
         lnb_pkg::RX_IDLE:
         begin
            rc_nxt = {1'b0, lnb_pkg::DIV_RST[15:1]};
            if (prev_r && !s2_r)
               rs_nxt = lnb_pkg::RX_START;
         end
         lnb_pkg::RX_START:
            if (rc_r == 16'h0000)
            begin
               rs_nxt = s2_r ? lnb_pkg::RX_IDLE : lnb_pkg::RX_BITS;
               rb_nxt = 4'h0;
            end
         lnb_pkg::RX_BITS:
            if (rc_r == 16'h0000)
            begin
               rsh_nxt = {s2_r, rsh_r[7:1]};
               rb_nxt  = 4'(rb_r + 4'h1);
               if (rb_r == 4'(lnb_pkg::DATA_BITS - 4'h1))
                  rs_nxt = lnb_pkg::RX_STOP;
            end
         lnb_pkg::RX_STOP:
            if (rc_r == 16'h0000)
            begin
               rv_nxt    = 1'b1;
               rbyte_nxt = rsh_r;
               fe_nxt    = ~s2_r;
               rs_nxt    = s2_r ? lnb_pkg::RX_IDLE : lnb_pkg::RX_BRKWAIT;
            end
         lnb_pkg::RX_BRKWAIT:
            if (s2_r)
               rs_nxt = lnb_pkg::RX_IDLE;
         default:
            rs_nxt = lnb_pkg::RX_IDLE;
      endcase
   end

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         st_r <= lnb_pkg::TX_IDLE;
         cnt_r <= 16'h0000;
         bit_r <= 4'h0;
         sh_r <= 8'h00;
         drv_r <= 1'b1;
         busy_r <= 1'b0;
         s1_r <= 1'b1;
         s2_r <= 1'b1;
         prev_r <= 1'b1;
         rs_r <= lnb_pkg::RX_IDLE;
         rc_r <= 16'h0000;
         rb_r <= 4'h0;
         rsh_r <= 8'h00;
         rbyte_r <= 8'h00;
         rv_r <= 1'b0;
         fe_r <= 1'b0;
      end
      else if (ce_i)
      begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         bit_r <= bit_nxt;
         sh_r <= sh_nxt;
         drv_r <= drv_nxt;
         busy_r <= busy_nxt;
         s1_r <= link.line;
         s2_r <= s1_r;
         prev_r <= s2_r;
         rs_r <= rs_nxt;
         rc_r <= rc_nxt;
         rb_r <= rb_nxt;
         rsh_r <= rsh_nxt;
         rbyte_r <= rbyte_nxt;
         rv_r <= rv_nxt;
         fe_r <= fe_nxt;
      end
   end

   assign link.node_drv = drv_r;
   assign busy_o        = busy_r;
   assign rx_valid_o    = rv_r;
   assign rx_byte_o     = rbyte_r;
   assign rx_framing_error_flag_o     = fe_r;
endmodule : lnb_node
`default_nettype wire

// >>> tb/lnb_monitor.sv
// wire checks on the single serial line between the port and the far node
`timescale 1ns/100ps
`default_nettype none
module lnb_monitor (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic dev_drv,
   input wire logic node_drv,
   input wire logic line
);
   localparam int BIT = lnb_pkg::BIT_CYC;
   localparam int BRK = 13 * BIT;

   // run lengths in sampled cycles, taken before the current edge updates them
   logic [31:0] dlo_r;
   logic [31:0] dhi_r;
   logic [31:0] nlo_r;
   logic [31:0] nhi_r;
   logic [31:0] nlast_r;
   logic        dseen_r;

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         dlo_r   <= '0;
         dhi_r   <= '0;
         nlo_r   <= '0;
         nhi_r   <= '0;
         nlast_r <= '0;
         dseen_r <= 1'b0;
      end
      else
      begin
         dlo_r   <= dev_drv ? '0 : dlo_r + 32'h1;
         dhi_r   <= dev_drv ? dhi_r + 32'h1 : '0;
         nlo_r   <= node_drv ? '0 : nlo_r + 32'h1;
         nhi_r   <= node_drv ? nhi_r + 32'h1 : '0;
         dseen_r <= dseen_r | ~dev_drv;
         if (node_drv && nlo_r != '0)
         begin
            nlast_r <= nlo_r;
         end
      end
   end

   default clocking mon_cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   a_reset_idle_drives: assert property (!$past(rstn_i) |-> dev_drv && node_drv && line)
      else $error("line driven low right after reset");
   a_dev_whole_bits: assert property ($rose(dev_drv) |-> (dlo_r % BIT) == 0)
      else $error("port low run is not whole bit times");
   a_dev_low_max: assert property (dlo_r <= BRK)
      else $error("port low run longer than a break");
   // first fall has no preceding frame, so the stop check waits for one
   a_dev_stop_high: assert property ($fell(dev_drv) && dseen_r |-> dhi_r >= BIT)
      else $error("port stop bit shorter than one bit time");
   a_node_whole_bits: assert property ($rose(node_drv) |-> (nlo_r % BIT) == 0)
      else $error("node low run is not whole bit times");
   a_node_low_max: assert property (nlo_r <= BRK)
      else $error("node low run longer than a break");
   a_node_delim_len: assert property ($fell(node_drv) && nlast_r == BRK |-> nhi_r == BIT)
      else $error("node delimiter after break is not one bit");
   a_node_sync_bits: assert property ($fell(node_drv) && nlast_r == BRK && nhi_r == BIT
      |-> ##BIT node_drv ##BIT !node_drv)
      else $error("node sync byte does not alternate");

   c_dev_break: cover property ($rose(dev_drv) && dlo_r == BRK);
   c_node_break: cover property ($rose(node_drv) && nlo_r == BRK);
   c_node_sync: cover property ($fell(node_drv) && nlast_r == BRK);
endmodule : lnb_monitor
`default_nettype wire

// >>> tb/uart_lin_break_handling_tb.sv
// self-checking bench: port and far node joined over one serial line
`timescale 1ns/100ps
`default_nettype none
module uart_lin_break_handling_tb;
   logic        clk_i      = 1'b0;
   logic        rstn_i     = 1'b0;
   logic        tx_enable  = 1'b0;
   logic        brk_set    = 1'b0;
   logic        tx_wr      = 1'b0;
   logic        rx_rd      = 1'b0;
   logic        wake_set   = 1'b0;
   logic        abd_set    = 1'b0;
   logic        dev_ce     = 1'b1;
   logic        slow       = 1'b0;
   logic        hdr        = 1'b0;
   logic        nb_valid   = 1'b0;
   logic [7:0]  tx_data    = 8'h00;
   logic [7:0]  nb_data    = 8'h00;
   logic        brk_req;
   logic        shift_empty;
   logic        space;
   logic        rx_flag;
   logic        framing_error_flag;
   logic        wake_en;
   logic        abd_en;
   logic [7:0]  rx_data;
   logic [15:0] div;
   logic        n_busy;
   logic        n_valid;
   logic        n_framing_error_flag;
   logic [7:0]  n_byte;
   int          failures   = 0;
   int          num_checks = 0;

   lnb_link_if link ();

   lnb_dev lnb_dev_i (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(dev_ce), .link(link),
      .tx_enable_i(tx_enable), .break_request_set_i(brk_set), .tx_write_i(tx_wr),
      .tx_data_i(tx_data), .rx_read_i(rx_rd), .wake_on_break_set_i(wake_set),
      .autobaud_set_i(abd_set), .break_request_o(brk_req), .tx_shift_empty_o(shift_empty),
      .tx_buffer_empty_flag_o(space), .rx_flag_o(rx_flag), .framing_error_flag_o(framing_error_flag),
      .rx_data_o(rx_data), .wake_on_break_enable_o(wake_en), .autobaud_enable_o(abd_en),
      .baud_div_o(div));

   lnb_node lnb_node_i (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(1'b1), .link(link),
      .header_i(hdr), .byte_valid_i(nb_valid), .byte_i(nb_data), .busy_o(n_busy),
      .rx_valid_o(n_valid), .rx_byte_o(n_byte), .rx_framing_error_flag_o(n_framing_error_flag));

   lnb_monitor lnb_monitor_i (.clk_i(clk_i), .rstn_i(rstn_i), .dev_drv(link.dev_drv),
      .node_drv(link.node_drv), .line(link.line));

   always #5 clk_i = ~clk_i;

   // half-rate enable so a measured rate differs from the reset divider
   always @(negedge clk_i)
      dev_ce = slow ? ~dev_ce : 1'b1;

   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic tally_and_finish;
      if (failures == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : tally_and_finish

   task automatic dev_write(input logic [7:0] d);
      @(negedge clk_i);
      tx_wr   = 1'b1;
      tx_data = d;
      @(negedge clk_i);
      tx_wr   = 1'b0;
   endtask : dev_write

   // node reports each byte by a one-cycle pulse, seen at the falling edge
   task automatic wait_node(input logic [7:0] exp, input logic eferr);
      int n;
      n = 0;
      while (n_valid !== 1'b1 && n < 3000)
      begin
         @(negedge clk_i);
         n++;
      end
      chk("node valid", {15'h0, n_valid}, 16'h0001);
      chk("node byte", {8'h00, n_byte}, {8'h00, exp});
      chk("node framing_error_flag", {15'h0, n_framing_error_flag}, {15'h0, eferr});
      @(negedge clk_i);
   endtask : wait_node

   task automatic dev_flag;
      int n;
      n = 0;
      while (rx_flag !== 1'b1 && n < 3000)
      begin
         @(negedge clk_i);
         n++;
      end
      chk("rx flag", {15'h0, rx_flag}, 16'h0001);
   endtask : dev_flag

   task automatic dev_read;
      @(negedge clk_i);
      rx_rd = 1'b1;
      @(negedge clk_i);
      rx_rd = 1'b0;
      chk("rx flag cleared", {15'h0, rx_flag}, 16'h0000);
   endtask : dev_read

   task automatic node_header;
      repeat (200) @(negedge clk_i);
      hdr = 1'b1;
      @(negedge clk_i);
      hdr = 1'b0;
      chk("node busy", {15'h0, n_busy}, 16'h0001);
   endtask : node_header

   initial
   begin
      repeat (3) @(negedge clk_i);
      rstn_i = 1'b1;
      repeat (2) @(negedge clk_i);
      chk("reset state", {brk_req, shift_empty, space, rx_flag, framing_error_flag, wake_en, abd_en,
         1'b0, rx_data}, 16'h6000);
      chk("reset divider", div, lnb_pkg::DIV_RST);
      // header from the port: enable, break, dummy, sync
      tx_enable = 1'b1;
      brk_set   = 1'b1;
      @(negedge clk_i);
      brk_set   = 1'b0;
      dev_write(8'ha5);
      chk("break pending", {15'h0, brk_req}, 16'h0001);
      dev_write(lnb_pkg::SYNC_BYTE);
      chk("shift busy", {15'h0, shift_empty}, 16'h0000);
      chk("space in break", {15'h0, space}, 16'h0001);
      wait_node(8'h00, 1'b1);
      chk("break still pending", {15'h0, brk_req}, 16'h0001);
      wait_node(lnb_pkg::SYNC_BYTE, 1'b0);
      chk("break cleared", {15'h0, brk_req}, 16'h0000);
      repeat (200) @(negedge clk_i);
      chk("shift idle", {15'h0, shift_empty}, 16'h0001);
      // fill while disabled: third write is refused
      tx_enable = 1'b0;
      dev_write(8'h81);
      dev_write(8'h3c);
      chk("buffer full", {15'h0, space}, 16'h0000);
      dev_write(8'hff);
      chk("held idle", {15'h0, shift_empty}, 16'h0001);
      tx_enable = 1'b1;
      wait_node(8'h81, 1'b0);
      wait_node(8'h3c, 1'b0);
      repeat (200) @(negedge clk_i);
      chk("full write dropped", {15'h0, shift_empty}, 16'h0001);
      // the port hears its own frames, so that flag is cleared first
      dev_read();
      // ordinary byte from the node
      nb_data  = 8'h96;
      nb_valid = 1'b1;
      @(negedge clk_i);
      nb_valid = 1'b0;
      dev_flag();
      chk("rx byte", {framing_error_flag, 7'h00, rx_data}, 16'h0096);
      dev_read();
      // break received through the framing path
      node_header();
      dev_flag();
      chk("rx break", {framing_error_flag, 7'h00, rx_data}, 16'h8000);
      dev_read();
      dev_flag();
      chk("rx sync", {framing_error_flag, 7'h00, rx_data}, 16'h0055);
      dev_read();
      // wake on break, then the following byte
      wake_set = 1'b1;
      @(negedge clk_i);
      wake_set = 1'b0;
      chk("wake set", {15'h0, wake_en}, 16'h0001);
      node_header();
      dev_flag();
      chk("wake cleared", {15'h0, wake_en}, 16'h0000);
      dev_read();
      dev_flag();
      chk("byte after wake", {framing_error_flag, 7'h00, rx_data}, 16'h0055);
      dev_read();
      // wake plus auto-baud: rate taken from the sync after the break
      wake_set = 1'b1;
      abd_set  = 1'b1;
      @(negedge clk_i);
      wake_set = 1'b0;
      abd_set  = 1'b0;
      node_header();
      dev_flag();
      chk("abd waits past break", {15'h0, abd_en}, 16'h0001);
      dev_read();
      slow = 1'b1;
      dev_flag();
      chk("abd cleared", {15'h0, abd_en}, 16'h0000);
      chk("abd divider", div, 16'((4 * lnb_pkg::BIT_CYC) >> lnb_pkg::ABD_SHIFT));
      slow = 1'b0;
      dev_read();
      tally_and_finish();
   end

   // the sequence needs about 13500 cycles; over four times that is a hang
   initial
   begin
      repeat (60000) @(posedge clk_i);
      failures++;
      tally_and_finish();
   end
endmodule : uart_lin_break_handling_tb
`default_nettype wire
